// file: pkg/ram_guard_if.sv
// carries one data access and its segment verdict between the checker and the guard
// assumes both ends on ref_clk
interface ram_guard_if;
   logic [15:0] addr;
   logic [1:0] code_seg;
   logic valid;
   logic deny;
   modport checker_end (output addr, output code_seg, output valid, input deny);
   modport guard_end (input addr, input code_seg, input valid, output deny);
endinterface

// file: pkg/stack_limit_checker_map.svh
// constants for the stack limit checker: addresses, widths, fixed bounds
// assumes a 16-bit byte-addressed data space with word-aligned stack
`ifndef STACK_LIMIT_CHECKER_MAP_SVH
`define STACK_LIMIT_CHECKER_MAP_SVH
`define SLC_ADDR_W 16
`define SLC_UNDERFLOW_ADDR 16'h0800
`define SLC_WORD_STEP 16'h0002
`define SLC_SP_RESET 16'h0800
`endif

// file: pkg/stack_limit_checker_pkg.sv
// types for the stack limit checker
// assumes the map header is compiled alongside
package stack_limit_checker_pkg;
   typedef enum logic [3:0] {
      OP_IDLE = 4'h1,
      OP_PUSH = 4'h2,
      OP_POP = 4'h4,
      OP_INDIRECT = 4'h8
   } op_type;
   typedef enum logic [1:0] {
      SEG_USER = 2'h0,
      SEG_BOOT = 2'h1,
      SEG_SECURE = 2'h2
   } seg_type;
endpackage

// file: rtl/ram_segment_guard.sv
// combinational secure RAM segment guard
// assumes window bounds are stable while protection is on
module ram_segment_guard #(
   parameter logic [15:0] BOOT_LO = 16'h0800,
   parameter logic [15:0] BOOT_HI = 16'h08FF,
   parameter logic [15:0] SEC_LO = 16'h0900,
   parameter logic [15:0] SEC_HI = 16'h09FF
) (
   input wire logic boot_prot_en,
   input wire logic sec_prot_en,
   ram_guard_if.guard_end acc
);
   logic in_boot;
   logic in_sec;
   assign in_boot = acc.addr >= BOOT_LO && acc.addr <= BOOT_HI;
   assign in_sec = acc.addr >= SEC_LO && acc.addr <= SEC_HI;
   assign acc.deny = acc.valid &&
      ((boot_prot_en && in_boot && acc.code_seg != stack_limit_checker_pkg::SEG_BOOT) ||
       (sec_prot_en && in_sec && acc.code_seg != stack_limit_checker_pkg::SEG_SECURE));
endmodule

// file: rtl/stack_limit_checker.sv
// stack pointer keeper, stack limit checker and secure RAM gate
// assumes the core issues at most one stack operation per cycle
`include "stack_limit_checker_map.svh"

// What this block does
// - one working register doubles as stack pointer and stays a normal register.
// - pointer holds first free word; stack grows toward higher addresses.
// - push writes then increments; pop decrements then reads.
// - call push without exception clears the most significant byte of the stacked counter.
// - exception push puts the status low byte in the counter high byte.
// - limit register is not reset; contents unknown after reset.
// - limit bit 0 always reads zero, writes ignored.
// - every address formed from the pointer is compared with the limit.
// - push at pointer equal limit passes; the next push traps.
// - stack address below 0x0800 raises an underflow stack error.
// - boot secure RAM only serves code from the boot segment when enabled.
// - segment secure RAM only serves code from the secure segment when enabled.
module stack_limit_checker (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire stack_limit_checker_pkg::op_type op,
   input wire logic is_call,
   input wire logic is_exception,
   input wire logic [23:0] pc_value,
   input wire logic [7:0] status_low_byte,
   input wire logic [15:0] addr_offset,
   input wire logic wreg_we,
   input wire logic [15:0] wreg_wdata,
   input wire logic limit_we,
   input wire logic [15:0] limit_wdata,
   input wire logic [15:0] data_addr,
   input wire logic data_valid,
   input wire stack_limit_checker_pkg::seg_type code_seg,
   input wire logic boot_prot_en,
   input wire logic sec_prot_en,
   output logic [15:0] stack_pointer_reg,
   output logic [15:0] stack_limit_reg,
   output logic [15:0] effective_addr,
   output logic [23:0] push_word,
   output logic mem_write,
   output logic mem_read,
   output logic stack_error,
   output logic overflow_error,
   output logic underflow_error,
   output logic access_denied
);
   typedef struct packed {
      logic [15:0] sp;
      logic [15:0] ea;
      logic [23:0] pw;
      logic wr;
      logic rd;
      logic err;
      logic ovf;
      logic unf;
      logic deny;
   } state_type;

   state_type s_q;
   state_type s_d;
   logic [15:0] lim_q;
   logic [15:0] lim_d;
   logic [15:0] ea_c;
   logic ovf_c;
   logic unf_c;
   logic stack_op;

   ram_guard_if guard_bus ();

   ram_segment_guard #(
      .BOOT_LO(16'h0800),
      .BOOT_HI(16'h08FF),
      .SEC_LO(16'h0900),
      .SEC_HI(16'h09FF)
   ) u_guard (
      .boot_prot_en(boot_prot_en),
      .sec_prot_en(sec_prot_en),
      .acc(guard_bus.guard_end)
   );

   assign guard_bus.addr = data_addr;
   assign guard_bus.code_seg = code_seg;
   assign guard_bus.valid = data_valid;

   always_comb begin
      stack_op = op != stack_limit_checker_pkg::OP_IDLE;
      // pop pre-decrements; push uses the pointer as is, indirect adds addr_offset to it
      case (op)
         stack_limit_checker_pkg::OP_POP: ea_c = s_q.sp - `SLC_WORD_STEP;
         stack_limit_checker_pkg::OP_INDIRECT: ea_c = s_q.sp + addr_offset;
         default: ea_c = s_q.sp;
      endcase
      // push at sp == lim passes, so only addresses above the limit raise overflow
      ovf_c = stack_op && (ea_c > lim_q);
      unf_c = stack_op && (ea_c < `SLC_UNDERFLOW_ADDR);
   end

   always_comb begin
      s_d = s_q;
      lim_d = lim_q;
      s_d.wr = 1'b0;
      s_d.rd = 1'b0;
      s_d.err = ovf_c || unf_c;
      s_d.ovf = ovf_c;
      s_d.unf = unf_c;
      s_d.deny = guard_bus.deny;
      s_d.ea = stack_op ? ea_c : s_q.ea;
      case (op)
         stack_limit_checker_pkg::OP_PUSH: begin
            s_d.wr = 1'b1;
            s_d.sp = s_q.sp + `SLC_WORD_STEP;
            if (is_exception) begin
               s_d.pw = {status_low_byte, pc_value[15:0]};
            end else if (is_call) begin
               s_d.pw = {8'h00, pc_value[15:0]};
            end else begin
               s_d.pw = pc_value;
            end
         end
         stack_limit_checker_pkg::OP_POP: begin
            s_d.rd = 1'b1;
            s_d.sp = ea_c;
         end
         stack_limit_checker_pkg::OP_INDIRECT: begin
            s_d.rd = 1'b1;
         end
         default: begin
            // ordinary register write when no stack op this cycle
            if (wreg_we) begin
               s_d.sp = {wreg_wdata[15:1], 1'b0};
            end
         end
      endcase
      if (limit_we) begin
         lim_d = {limit_wdata[15:1], 1'b0};
      end
   end

   // limit has no reset on purpose, so it lives outside the state struct and its process
   always_ff @(posedge ref_clk) begin
      lim_q <= lim_d;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q.sp <= `SLC_SP_RESET;
         s_q.ea <= 16'h0000;
         s_q.pw <= 24'h000000;
         s_q.wr <= 1'b0;
         s_q.rd <= 1'b0;
         s_q.err <= 1'b0;
         s_q.ovf <= 1'b0;
         s_q.unf <= 1'b0;
         s_q.deny <= 1'b0;
      end else begin
         s_q.sp <= s_d.sp;
         s_q.ea <= s_d.ea;
         s_q.pw <= s_d.pw;
         s_q.wr <= s_d.wr;
         s_q.rd <= s_d.rd;
         s_q.err <= s_d.err;
         s_q.ovf <= s_d.ovf;
         s_q.unf <= s_d.unf;
         s_q.deny <= s_d.deny;
      end
   end

   assign stack_pointer_reg = s_q.sp;
   assign stack_limit_reg = lim_q;
   assign effective_addr = s_q.ea;
   assign push_word = s_q.pw;
   assign mem_write = s_q.wr;
   assign mem_read = s_q.rd;
   assign stack_error = s_q.err;
   assign overflow_error = s_q.ovf;
   assign underflow_error = s_q.unf;
   assign access_denied = s_q.deny;

   a_push_increments: assert property (@(posedge ref_clk) disable iff (!rst_n)
      op == stack_limit_checker_pkg::OP_PUSH
         |=> stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002)
      else $error("push did not advance pointer by one word");
   a_pop_predecrements: assert property (@(posedge ref_clk) disable iff (!rst_n)
      op == stack_limit_checker_pkg::OP_POP |=> effective_addr == stack_pointer_reg
         && stack_pointer_reg == $past(stack_pointer_reg) - 16'h0002)
      else $error("pop address not the decremented pointer");
   a_call_msb_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      op == stack_limit_checker_pkg::OP_PUSH && is_call && !is_exception
         |=> push_word[23:16] == 8'h00)
      else $error("call push high byte not cleared");
   a_exc_status_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
      op == stack_limit_checker_pkg::OP_PUSH && is_exception
         |=> push_word[23:16] == $past(status_low_byte))
      else $error("exception push lacks status byte");
   a_limit_bit_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(limit_we) |-> stack_limit_reg == ($past(limit_wdata) & 16'hFFFE))
      else $error("limit write not word aligned");
   a_gp_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      op == stack_limit_checker_pkg::OP_IDLE && wreg_we
         |=> stack_pointer_reg == {$past(wreg_wdata[15:1]), 1'b0})
      else $error("general write did not reach pointer");
   a_push_at_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      op == stack_limit_checker_pkg::OP_PUSH && stack_pointer_reg == stack_limit_reg
         && stack_pointer_reg >= 16'h0800 |=> !overflow_error)
      else $error("push at limit trapped");
   a_push_over_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      op == stack_limit_checker_pkg::OP_PUSH && stack_pointer_reg > stack_limit_reg
         |=> stack_error && overflow_error)
      else $error("push above limit not trapped");
   a_underflow_trap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      op == stack_limit_checker_pkg::OP_PUSH && stack_pointer_reg < 16'h0800
         |=> underflow_error
         ##1 (!stack_error || $past(op) != stack_limit_checker_pkg::OP_IDLE))
      else $error("underflow not flagged");
   a_boot_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
      data_valid && boot_prot_en && data_addr >= 16'h0800 && data_addr <= 16'h08FF
         && code_seg != stack_limit_checker_pkg::SEG_BOOT |=> access_denied)
      else $error("boot secure ram access not denied");
   a_secure_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
      data_valid && sec_prot_en && data_addr >= 16'h0900 && data_addr <= 16'h09FF
         && code_seg != stack_limit_checker_pkg::SEG_SECURE |=> access_denied)
      else $error("segment secure ram access not denied");
endmodule

// file: verification/core_model.sv
// partner model: the core's address generator issuing stack ops and limit writes
// assumes the checker samples its inputs on the rising edge of ref_clk
module core_model (
   input wire logic ref_clk,
   output stack_limit_checker_pkg::op_type op,
   output logic is_call,
   output logic is_exception,
   output logic [23:0] pc_value,
   output logic [7:0] status_low_byte,
   output logic [15:0] addr_offset,
   output logic limit_we,
   output logic [15:0] limit_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      op = stack_limit_checker_pkg::OP_IDLE;
      {is_call, is_exception, limit_we} = 3'h0;
      {pc_value, status_low_byte, addr_offset, limit_wdata} = 64'h0;
   end
   task automatic issue(input stack_limit_checker_pkg::op_type o, input logic c, input logic e,
      input logic [23:0] pc, input logic [7:0] st, input logic [15:0] off);
      @(posedge ref_clk);
      op <= o;
      {is_call, is_exception, pc_value, status_low_byte, addr_offset} <= {c, e, pc, st, off};
      @(posedge ref_clk);
      op <= stack_limit_checker_pkg::OP_IDLE;
      // qualifiers mean nothing once the op is gone, so scramble them
      {pc_value, status_low_byte, addr_offset} <= ~{pc, st, off};
   endtask
   task automatic set_limit(input logic [15:0] v);
      @(posedge ref_clk);
      limit_we <= 1'b1;
      limit_wdata <= v;
      @(posedge ref_clk);
      limit_we <= 1'b0; // one idle edge always follows, never an indirect read at once
      limit_wdata <= ~v;
   endtask
endmodule

// file: verification/stack_limit_checker_tb.sv
// self-checking bench for the stack limit checker with a core model on its op side
// assumes default guard windows of the design
`include "stack_limit_checker_map.svh"
module stack_limit_checker_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_n, wreg_we, limit_we, data_valid, boot_prot_en, sec_prot_en;
   logic is_call, is_exception, mem_write, mem_read, stack_error, overflow_error;
   logic underflow_error, access_denied;
   logic [7:0] status_low_byte;
   logic [15:0] addr_offset, wreg_wdata, limit_wdata, data_addr, stack_pointer_reg;
   logic [15:0] stack_limit_reg, effective_addr, sp_exp, lim_exp;
   logic [23:0] pc_value, push_word;
   stack_limit_checker_pkg::op_type op;
   stack_limit_checker_pkg::seg_type code_seg;
   int num_errors, cmp_count, seed;
   stack_limit_checker stack_limit_checker_i (.ref_clk(ref_clk), .rst_n(rst_n), .op(op),
      .is_call(is_call), .is_exception(is_exception), .pc_value(pc_value),
      .status_low_byte(status_low_byte), .addr_offset(addr_offset), .wreg_we(wreg_we),
      .wreg_wdata(wreg_wdata), .limit_we(limit_we), .limit_wdata(limit_wdata),
      .data_addr(data_addr), .data_valid(data_valid), .code_seg(code_seg),
      .boot_prot_en(boot_prot_en), .sec_prot_en(sec_prot_en),
      .stack_pointer_reg(stack_pointer_reg), .stack_limit_reg(stack_limit_reg),
      .effective_addr(effective_addr), .push_word(push_word), .mem_write(mem_write),
      .mem_read(mem_read), .stack_error(stack_error), .overflow_error(overflow_error),
      .underflow_error(underflow_error), .access_denied(access_denied));
   core_model core_model_i (.ref_clk(ref_clk), .op(op), .is_call(is_call),
      .is_exception(is_exception), .pc_value(pc_value), .status_low_byte(status_low_byte),
      .addr_offset(addr_offset), .limit_we(limit_we), .limit_wdata(limit_wdata));
   task automatic chk_val(input string n, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      chk_val(n, {23'h0, e}, {23'h0, g});
   endtask
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic stack_op(input stack_limit_checker_pkg::op_type o, input logic c,
      input logic e, input logic [23:0] pc, input logic [7:0] st, input logic [15:0] off);
      logic [15:0] ea;
      logic up;
      up = o == stack_limit_checker_pkg::OP_PUSH;
      ea = up ? sp_exp : (o == stack_limit_checker_pkg::OP_POP ? sp_exp - 16'h2 : sp_exp + off);
      core_model_i.issue(o, c, e, pc, st, off);
      #1;
      if (o != stack_limit_checker_pkg::OP_INDIRECT) begin
         sp_exp = up ? sp_exp + `SLC_WORD_STEP : ea;
      end
      chk_bit("read", !up, mem_read);
      chk_val("pointer", {8'h0, sp_exp}, {8'h0, stack_pointer_reg});
      chk_val("ea", {8'h0, ea}, {8'h0, effective_addr});
      chk_bit("overflow", ea > lim_exp, overflow_error);
      chk_bit("underflow", ea < `SLC_UNDERFLOW_ADDR, underflow_error);
      chk_bit("error", ea > lim_exp || ea < `SLC_UNDERFLOW_ADDR, stack_error);
      chk_bit("write", up, mem_write);
      if (up)
         chk_val("push word", e ? {st, pc[15:0]} : (c ? {8'h0, pc[15:0]} : pc), push_word);
   endtask
   task automatic write_limit(input logic [15:0] v);
      core_model_i.set_limit(v);
      lim_exp = v & 16'hFFFE;
      #1 chk_val("limit", {8'h0, lim_exp}, {8'h0, stack_limit_reg});
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      #1000000;
      num_errors++;
      report_and_stop;
   end
   initial begin
      {num_errors, cmp_count, seed} = {32'd0, 32'd0, 32'd33};
      {rst_n, wreg_we, data_valid, boot_prot_en, sec_prot_en} = 5'h0;
      {wreg_wdata, data_addr} = 32'h0;
      code_seg = stack_limit_checker_pkg::SEG_USER;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      sp_exp = `SLC_SP_RESET;
      write_limit(16'h0807);
      repeat (5) stack_op(stack_limit_checker_pkg::OP_PUSH, 1'b1, 1'b0, 24'hA51234, 8'h3C,
         16'h0000);
      stack_op(stack_limit_checker_pkg::OP_PUSH, 1'b0, 1'b1, 24'h7E5678, 8'hC3,
         16'h0000);
      stack_op(stack_limit_checker_pkg::OP_PUSH, 1'b1, 1'b1, 24'h129ABC, 8'h5A,
         16'h0000);
      stack_op(stack_limit_checker_pkg::OP_INDIRECT, 1'b0, 1'b0, 24'h000000, 8'h00,
         16'hF000);
      repeat (9) stack_op(stack_limit_checker_pkg::OP_POP, 1'b0, 1'b0, 24'h000000, 8'h00,
         16'h0000);
      // pointer now sits below the floor, so this push must trap as underflow
      stack_op(stack_limit_checker_pkg::OP_PUSH, 1'b0, 1'b0, 24'h3C0FF0, 8'h00,
         16'h0000);
      @(posedge ref_clk);
      wreg_we <= 1'b1;
      wreg_wdata <= 16'h0901;
      @(posedge ref_clk);
      wreg_we <= 1'b0;
      sp_exp = 16'h0900;
      #1 chk_val("gp write", {8'h0, sp_exp}, {8'h0, stack_pointer_reg});
      write_limit(16'h0A01);
      repeat (60) stack_op(stack_limit_checker_pkg::op_type'(4'h2 << ({$random(seed)} % 3)),
         1'($random(seed)), 1'($random(seed)), 24'($random(seed)), 8'($random(seed)),
         16'($random(seed)) & 16'h03FE);
      // a reset in mid-run reloads the pointer to 0x0800 but must leave the limit alone
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      sp_exp = `SLC_SP_RESET;
      #1 chk_val("reset pointer", {8'h0, sp_exp}, {8'h0, stack_pointer_reg});
      chk_val("kept limit", {8'h0, lim_exp}, {8'h0, stack_limit_reg});
      chk_bit("reset error", 1'b0, stack_error);
      repeat (40) begin
         @(posedge ref_clk);
         data_valid <= 1'b1;
         data_addr <= 16'h07F0 + 16'({$random(seed)} % 544);
         code_seg <= stack_limit_checker_pkg::seg_type'({$random(seed)} % 3);
         {boot_prot_en, sec_prot_en} <= 2'($random(seed));
         @(posedge ref_clk);
         data_valid <= 1'b0;
         #1 chk_bit("denied", (boot_prot_en && data_addr inside {[16'h0800:16'h08FF]}
            && code_seg != stack_limit_checker_pkg::SEG_BOOT) || (sec_prot_en
            && data_addr inside {[16'h0900:16'h09FF]}
            && code_seg != stack_limit_checker_pkg::SEG_SECURE), access_denied);
      end
      report_and_stop;
   end
endmodule
